// ---- design/crpc_core_regulator_power_control.sv ----
/*
 * crpc_core_regulator_power_control: latched enable for the core regulator.
 * assumes: i_rstn comes from the supply-valid detector and drops on supply
 * fail; fabric and counter inputs are synchronous to i_clock; the wake pin
 * and test-reset pin are asynchronous board signals.
 */
`timescale 1ns/1ps
module crpc_core_regulator_power_control #(
	parameter logic [crpc_pkg::INIT_CFG_W-1:0] INIT_POWER_STATE = 2'h1,
	parameter int GOOD_DELAY = crpc_pkg::GOOD_DELAY_CYC
) (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire crpc_pkg::crpc_wake_in_t i_wake,
	output crpc_pkg::crpc_status_t o_status
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		crpc_pkg::crpc_state_t state;
		logic en;
		logic [crpc_pkg::GOOD_CNT_W-1:0] good_cnt;
		crpc_pkg::crpc_status_t status;
	} crpc_regs_t;

	localparam logic [crpc_pkg::GOOD_CNT_W-1:0] GOOD_LIMIT = GOOD_DELAY[crpc_pkg::GOOD_CNT_W-1:0];
	localparam logic [crpc_pkg::GOOD_CNT_W-1:0] GOOD_STEP = 4'h1;

	crpc_regs_t r_q;
	crpc_regs_t r_d;
	logic wake_n_sync;
	logic trst_sync;
	logic match_gated;
	logic init_on;
	logic wake_any;
	logic reg_on;

	// ----------------------------------------------------------------
	// input conditioning
	// ----------------------------------------------------------------
	// idle-high reset value so a wake is never seen during reset release
	crpc_sync #(
		.STAGES(crpc_pkg::SYNC_STAGES),
		.RESET_VAL(1'b1)
	) u_wake_sync (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_async(i_wake.wake_request_n),
		.o_sync(wake_n_sync)
	);

	// test-reset pin has a pull-up: assume high until proven low
	crpc_sync #(
		.STAGES(crpc_pkg::SYNC_STAGES),
		.RESET_VAL(1'b1)
	) u_trst_sync (
		.i_clock(i_clock),
		.i_rstn(i_rstn),
		.i_async(i_wake.test_reset),
		.o_sync(trst_sync)
	);

	assign match_gated = i_wake.counter_match_out & i_wake.match_wake_enable;
	assign init_on = (INIT_POWER_STATE != crpc_pkg::INIT_CFG_OFF);
	assign wake_any = ~wake_n_sync | match_gated;

	// ----------------------------------------------------------------
	// start decode
	// ----------------------------------------------------------------
	// shutdown always wins over a start request in the same cycle
	function automatic logic start_ok(input logic req, input logic shut);
		return req & ~shut;
	endfunction

	// ----------------------------------------------------------------
	// control
	// ----------------------------------------------------------------
	always_comb begin
		r_d = r_q;
		case (r_q.state)
			crpc_pkg::CRPC_ST_INIT: begin
				// init state only acts once, at reset release
				if (start_ok(init_on, i_wake.regulator_shutdown)) begin
					r_d.en = 1'b1;
					r_d.state = crpc_pkg::CRPC_ST_ON;
				end else begin
					r_d.state = crpc_pkg::CRPC_ST_OFF;
				end
			end
			crpc_pkg::CRPC_ST_OFF: begin
				if (start_ok(wake_any, i_wake.regulator_shutdown)) begin
					r_d.en = 1'b1;
					r_d.state = crpc_pkg::CRPC_ST_ON;
				end
			end
			crpc_pkg::CRPC_ST_ON: begin
				// wake sources cannot clear; only the fabric can
				if (i_wake.regulator_shutdown) begin
					r_d.en = 1'b0;
					r_d.state = crpc_pkg::CRPC_ST_OFF;
				end
			end
			default: begin
				r_d.en = 1'b0;
				r_d.state = crpc_pkg::CRPC_ST_OFF;
			end
		endcase
		// test reset overrides the output only; the latch is left untouched
		reg_on = r_d.en | trst_sync;
		if (!reg_on) begin
			r_d.good_cnt = '0;
		end else if (r_q.good_cnt != GOOD_LIMIT) begin
			r_d.good_cnt = r_q.good_cnt + GOOD_STEP;
		end
		r_d.status.core_regulator_en = reg_on;
		r_d.status.core_good = reg_on && (r_d.good_cnt == GOOD_LIMIT);
		r_d.status.core_powered = r_d.status.core_good;
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			r_q <= '{state: crpc_pkg::CRPC_ST_INIT, en: 1'b0, good_cnt: '0, status: '0};
		end else begin
			r_q <= r_d;
		end
	end

	assign o_status = r_q.status;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_shutdown_clears_en: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		(i_wake.regulator_shutdown && !trst_sync) |=> !o_status.core_regulator_en)
		else $error("regulator enabled while fabric shutdown active");

	chk_latch_holds: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		(r_q.en && !i_wake.regulator_shutdown) |=> r_q.en)
		else $error("latched enable dropped without shutdown");

	chk_only_fabric_clears: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		$fell(r_q.en) |-> $past(i_wake.regulator_shutdown))
		else $error("enable cleared by something other than shutdown");

	chk_wake_pin_sets: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		(!i_wake.wake_request_n && !i_wake.regulator_shutdown) [*3] |=> r_q.en)
		else $error("wake pin did not set enable within three cycles");

	chk_match_gated: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		(r_q.state == crpc_pkg::CRPC_ST_OFF && wake_n_sync && !i_wake.match_wake_enable)
		|=> !r_q.en)
		else $error("counter match woke regulator while disabled");

	chk_match_sets: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		(r_q.state == crpc_pkg::CRPC_ST_OFF && match_gated && !i_wake.regulator_shutdown)
		|=> r_q.en)
		else $error("counter match did not set enable");

	chk_trst_forces_on: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		trst_sync |=> o_status.core_regulator_en)
		else $error("test reset high but regulator off");

	chk_init_start: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		(r_q.state == crpc_pkg::CRPC_ST_INIT && !i_wake.regulator_shutdown)
		|=> (r_q.en == init_on))
		else $error("init configuration not applied at reset release");

	chk_good_needs_en: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		o_status.core_good |-> (o_status.core_regulator_en && o_status.core_powered))
		else $error("core good without regulator enable");

	chk_reset_clears: assert property (
		@(posedge i_clock)
		$rose(i_rstn) |-> (r_q.state == crpc_pkg::CRPC_ST_INIT && !r_q.en))
		else $error("control state not cleared by reset");

	chk_shutdown_blocks_wake: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		(r_q.state != crpc_pkg::CRPC_ST_ON && i_wake.regulator_shutdown) |=> !r_q.en)
		else $error("enable set while fabric shutdown active");

	chk_en_needs_source: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		$rose(r_q.en)
		|-> $past(wake_any || (r_q.state == crpc_pkg::CRPC_ST_INIT && init_on)))
		else $error("enable set with no wake source");

	chk_trst_no_latch: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		(r_q.state == crpc_pkg::CRPC_ST_OFF && !wake_any) |=> !r_q.en)
		else $error("latched enable set with no wake source present");

	chk_sync_delay: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		$fell(wake_n_sync) |-> !$past(i_wake.wake_request_n, 2))
		else $error("wake pin reached the logic without two sync stages");

	// assumes a settle count of two or more cycles
	chk_good_lags_en: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		$rose(o_status.core_good) |-> $past(o_status.core_regulator_en))
		else $error("core good rose together with the regulator enable");
endmodule

// ---- design/crpc_pkg.sv ----
/*
 * crpc_pkg: shared types and constants for the core regulator power control block.
 * assumes: single 250 MHz clock domain, supply-valid detector drives the reset.
 */
package crpc_pkg;

	// ----------------------------------------------------------------
	// init configuration encoding
	// ----------------------------------------------------------------
	localparam int INIT_CFG_W = 2;
	// any configuration other than all-zero means power on at reset release
	localparam logic [INIT_CFG_W-1:0] INIT_CFG_OFF = 2'h0;
	localparam int SYNC_STAGES = 2;
	localparam int CLK_PERIOD_PS = 4000;
	// settle time after enable before core is reported good
	localparam int GOOD_DELAY_NS = 20;
	localparam int GOOD_DELAY_CYC = (GOOD_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int GOOD_CNT_W = 4;

	typedef enum logic [1:0] {
		CRPC_ST_INIT,
		CRPC_ST_OFF,
		CRPC_ST_ON
	} crpc_state_t;

	typedef struct packed {
		logic wake_request_n;
		logic counter_match_out;
		logic match_wake_enable;
		logic regulator_shutdown;
		logic test_reset;
	} crpc_wake_in_t;

	typedef struct packed {
		logic core_regulator_en;
		logic core_good;
		logic core_powered;
	} crpc_status_t;

endpackage

// ---- design/crpc_sync.sv ----
/*
 * crpc_sync: multi-stage level synchroniser.
 * assumes: destination clock free running; input may change at any time.
 */
`timescale 1ns/1ps
module crpc_sync #(
	parameter int STAGES = 2,
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic i_clock,
	input wire logic i_rstn,
	input wire logic i_async,
	output logic o_sync
);
	logic [STAGES-1:0] chain_q;

	// only the last stage is read outside this module
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			chain_q <= {STAGES{RESET_VAL}};
		end else begin
			chain_q <= {chain_q[STAGES-2:0], i_async};
		end
	end

	assign o_sync = chain_q[STAGES-1];
endmodule

// ---- tb/crpc_partner.sv ----
/* crpc_partner: fabric and counter model.
   assumes: bench changes requests at the falling edge. */
`timescale 1ns/1ps
module crpc_partner (
	input wire logic i_shut_req,
	input wire logic i_match_req,
	output logic o_match,
	output logic o_shut
);
	// raw compare result: gating by the wake-on-match setting is the block's job
	assign o_match = i_match_req;
	assign o_shut = i_shut_req;
endmodule

// ---- tb/crpc_core_regulator_power_control_tb.sv ----
/* crpc_core_regulator_power_control_tb: directed bench for the regulator enable.
   assumes: two instances, init on and init off, share all inputs. */
`timescale 1ns/1ps
module crpc_core_regulator_power_control_tb;
	localparam int GD = 5;
	logic i_clock = 1'b0;
	logic i_rstn = 1'b0;
	logic shut_req = 1'b0;
	logic match_req = 1'b0;
	logic match_en = 1'b0;
	logic pin_n = 1'b1;
	logic trst = 1'b0;
	logic match;
	logic shut;
	crpc_pkg::crpc_wake_in_t w;
	crpc_pkg::crpc_status_t st;
	crpc_pkg::crpc_status_t st_off;
	int n_errors = 0;
	int n_checks = 0;
	always #2 i_clock = ~i_clock;
	assign w = {pin_n, match, match_en, shut, trst};
	crpc_partner part_u (.i_shut_req(shut_req), .i_match_req(match_req),
		.o_match(match), .o_shut(shut));
	crpc_core_regulator_power_control #(.INIT_POWER_STATE(2'h1), .GOOD_DELAY(GD)) dut_u (
		.i_clock(i_clock), .i_rstn(i_rstn), .i_wake(w), .o_status(st));
	crpc_core_regulator_power_control #(.INIT_POWER_STATE(2'h0), .GOOD_DELAY(GD)) dut_off_u (
		.i_clock(i_clock), .i_rstn(i_rstn), .i_wake(w), .o_status(st_off));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(negedge i_clock);
	endtask
	task automatic check(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %b expected %b", $time, got, exp);
		end
	endtask
	task automatic shut_pulse();
		shut_req = 1'b1;
		cyc(1);
		shut_req = 1'b0;
		cyc(1);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_init();
		cyc(3);
		check(st.core_regulator_en, 1'b1);
		check(st_off.core_regulator_en, 1'b0);
		check(st.core_good, 1'b0);
		cyc(GD + 1);
		check(st.core_good, 1'b1);
		check(st.core_powered, 1'b1);
		$display("init done");
	endtask
	task automatic t_shutdown();
		shut_req = 1'b1;
		cyc(1);
		check(st.core_regulator_en, 1'b0);
		pin_n = 1'b0;
		cyc(4);
		check(st_off.core_regulator_en, 1'b0);
		check(st.core_good, 1'b0);
		pin_n = 1'b1;
		cyc(3);
		shut_req = 1'b0;
		cyc(3);
		check(st.core_regulator_en, 1'b0);
		$display("shutdown done");
	endtask
	task automatic t_pin();
		pin_n = 1'b0;
		cyc(2);
		check(st.core_regulator_en, 1'b0);
		cyc(2);
		check(st.core_regulator_en, 1'b1);
		pin_n = 1'b1;
		cyc(5);
		check(st.core_regulator_en, 1'b1);
		shut_pulse();
		check(st.core_regulator_en, 1'b0);
		$display("pin wake done");
	endtask
	task automatic t_match();
		match_req = 1'b1;
		cyc(3);
		check(st.core_regulator_en, 1'b0);
		match_en = 1'b1;
		cyc(1);
		check(st.core_regulator_en, 1'b1);
		match_req = 1'b0;
		match_en = 1'b0;
		cyc(2);
		check(st_off.core_regulator_en, 1'b1);
		shut_pulse();
		$display("match wake done");
	endtask
	task automatic t_trst();
		trst = 1'b1;
		shut_req = 1'b1;
		cyc(4);
		check(st_off.core_regulator_en, 1'b1);
		check(st.core_regulator_en, 1'b1);
		trst = 1'b0;
		shut_req = 1'b0;
		cyc(4);
		check(st_off.core_regulator_en, 1'b0);
		$display("test reset done");
	endtask
	task automatic t_fail();
		match_req = 1'b1;
		match_en = 1'b1;
		cyc(1);
		match_req = 1'b0;
		cyc(1);
		i_rstn = 1'b0;
		cyc(1);
		check(st_off.core_regulator_en, 1'b0);
		i_rstn = 1'b1;
		cyc(4);
		check(st_off.core_regulator_en, 1'b0);
		$display("supply fail done");
	endtask
	initial begin
		cyc(8);
		i_rstn = 1'b1;
		t_init();
		t_shutdown();
		t_pin();
		t_match();
		t_trst();
		t_fail();
		print_verdict();
	end
	// tests need about 60 cycles; the limit leaves wide margin
	initial begin
		#4000;
		n_errors++;
		print_verdict();
	end
endmodule
